// >>> core/exec_defines.svh
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
// How it works
// - Return loads popped stack top into counter, two cycles
// - Shadow flag set restores accumulator, flags, bank
// - Return keeps latches unchanged; flags change only by shadow restore
// - Rotate left via carry in one cycle
// - Destination bit zero writes accumulator, else file
// - Rotate updates only carry, negative, zero flags
// - File operand is instruction low byte

// Register byte offsets on the Avalon-MM slave
`define REG_INSTR        6'h00
`define REG_CTRL         6'h04
`define REG_ACC          6'h08
`define REG_FLAGS        6'h0C
`define REG_BANK         6'h10
`define REG_ACC_SHD      6'h14
`define REG_FLAG_SHD     6'h18
`define REG_BANK_SHD     6'h1C
`define REG_STACK_TOP    6'h20
`define REG_PC           6'h24
`define REG_UPPER_LATCH  6'h28
`define REG_HIGH_LATCH   6'h2C
`define REG_FILE_ADDR    6'h30
`define REG_FILE_DATA    6'h34

// Instruction encodings
`define RET_PATTERN      15'h0009
`define ROT_PATTERN      6'h0D
`define ROT_TOP          15
`define ROT_BOTTOM       10
`define DEST_BIT         9
`define ACCESS_BIT       8

// Flag bit positions
`define FLAG_C           0
`define FLAG_Z           2
`define FLAG_N           4

// Access bank split and its two banks
`define ACCESS_SPLIT     8'h60
`define ACCESS_LOW_BANK  4'h0
`define ACCESS_HIGH_BANK 4'hF

// Control register bits
`define CTRL_BUSY        0
`define CTRL_ILLEGAL     1

// Reset values
`define RST_BYTE         8'h00
`define RST_PC           21'h000000
`endif

// >>> core/exec_pkg.sv
package exec_pkg;
	// Decoded view of one instruction word
	typedef struct packed {
		logic       is_ret;
		logic       is_rot;
		logic       shadow;
		logic       dest;
		logic       access;
		logic [7:0] file;
	} decode_t;

	// Execution sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_RET_NOP
	} exec_state_t;
endpackage : exec_pkg

// >>> core/bank_addr_unit.sv
`timescale 1ns/1ns
`include "exec_defines.svh"
module bank_addr_unit
	import exec_pkg::*;
(
	input  wire logic [7:0]  file,
	input  wire logic        access,
	input  wire logic [3:0]  bank,
	output      logic [11:0] full_addr
);
	// Bank choice for the file operand
	always_comb begin
		if (access) begin
			full_addr = {bank, file};
		end else if (file < `ACCESS_SPLIT) begin
			full_addr = {`ACCESS_LOW_BANK, file};
		end else begin
			full_addr = {`ACCESS_HIGH_BANK, file};
		end
	end
endmodule : bank_addr_unit

// >>> core/subroutine_return_and_rotate_exec.sv
`timescale 1ns/1ns
`include "exec_defines.svh"
module subroutine_return_and_rotate_exec
	import exec_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output      logic [31:0] avs_readdata,
	output      logic        avs_waitrequest
);
	// Decode one instruction word into the fields the core uses
	function automatic decode_t decode(input logic [15:0] word);
		decode_t dec;
		dec.is_ret = (word[15:1] == `RET_PATTERN);
		dec.is_rot = (word[`ROT_TOP:`ROT_BOTTOM] == `ROT_PATTERN);
		dec.shadow = word[0];
		dec.dest   = word[`DEST_BIT];
		dec.access = word[`ACCESS_BIT];
		dec.file   = word[7:0];
		return dec;
	endfunction : decode

	// Architectural state
	exec_state_t state_q,     state_d;     // Sequencer
	logic [15:0] instr_q,     instr_d;     // Last launched word
	logic        illegal_q,   illegal_d;   // Sticky unknown opcode
	logic [7:0]  acc_q,       acc_d;       // Working accumulator
	logic [7:0]  flags_q,     flags_d;     // Flag register
	// Bank register and the three copies a return may restore
	logic [3:0]  bank_select_reg_q, bank_select_reg_d;
	logic [7:0]  accumulator_shadow_q, accumulator_shadow_d;
	logic [7:0]  flag_shadow_q, flag_shadow_d;
	logic [3:0]  bank_choice_shadow_q, bank_choice_shadow_d;
	// Stack top is a plain register here; no stack pointer moves
	logic [20:0] stack_top_entry_q, stack_top_entry_d;
	logic [20:0] pc_q,        pc_d;        // Program counter
	// Latches are only read back over the bus; a return leaves them
	logic [7:0]  counter_upper_latch_q, counter_upper_latch_d;
	logic [7:0]  counter_high_latch_q,  counter_high_latch_d;
	logic [11:0] file_addr_q, file_addr_d; // Software window pointer

	// Bus answer registers
	logic        waitreq_q,   waitreq_d;
	logic [31:0] rdata_q,     rdata_d;

	// Data memory: sixteen banks of 256 bytes
	logic [7:0]  file_mem [0:4095];
	logic        mem_we;
	logic [11:0] mem_addr;
	logic [7:0]  mem_wdata;

	// Decoded current instruction and its operand address
	decode_t     dec;
	logic [11:0] rot_addr;
	logic [7:0]  rot_src;
	logic [7:0]  rot_res;
	logic        bus_wr;
	logic        bus_rd;
	logic        launch;

	// One decoded view of the launched word, shared by every branch
	assign dec = decode(instr_q);

	// Operand address from file byte, access bit and bank register
	bank_addr_unit u_bank (
		.file      (dec.file),
		.access    (dec.access),
		.bank      (bank_select_reg_q),
		.full_addr (rot_addr)
	);

	assign rot_src = file_mem[rot_addr];

	// A bus transfer completes only while waitrequest is low
	// Writes are held off while busy, so a running instruction never
	// sees its operands change under it
	assign bus_wr = avs_write && !waitreq_q;
	assign bus_rd = avs_read && !waitreq_q;
	assign launch = bus_wr && (avs_address == `REG_INSTR);

	// Next-state logic for the sequencer, registers and bus
	always_comb begin
		state_d               = state_q;
		instr_d               = instr_q;
		illegal_d             = illegal_q;
		acc_d                 = acc_q;
		flags_d               = flags_q;
		bank_select_reg_d     = bank_select_reg_q;
		accumulator_shadow_d  = accumulator_shadow_q;
		flag_shadow_d         = flag_shadow_q;
		bank_choice_shadow_d  = bank_choice_shadow_q;
		stack_top_entry_d     = stack_top_entry_q;
		pc_d                  = pc_q;
		counter_upper_latch_d = counter_upper_latch_q;
		counter_high_latch_d  = counter_high_latch_q;
		file_addr_d           = file_addr_q;
		mem_we                = 1'b0;
		mem_addr              = file_addr_q;
		mem_wdata             = avs_writedata[7:0];
		rot_res               = {rot_src[6:0], flags_q[`FLAG_C]};

		// Software writes, accepted only when idle
		if (bus_wr) begin
			case (avs_address)
				`REG_INSTR: begin
					instr_d = avs_writedata[15:0];
					state_d = ST_EXEC;
				end
				`REG_CTRL: begin
					// Write one to clear the sticky error
					if (avs_writedata[`CTRL_ILLEGAL]) begin
						illegal_d = 1'b0;
					end
				end
				`REG_ACC:         acc_d = avs_writedata[7:0];
				`REG_FLAGS:       flags_d = avs_writedata[7:0];
				`REG_BANK:        bank_select_reg_d = avs_writedata[3:0];
				`REG_ACC_SHD: begin
					accumulator_shadow_d = avs_writedata[7:0];
				end
				`REG_FLAG_SHD:    flag_shadow_d = avs_writedata[7:0];
				`REG_BANK_SHD: begin
					bank_choice_shadow_d = avs_writedata[3:0];
				end
				`REG_STACK_TOP: begin
					stack_top_entry_d = avs_writedata[20:0];
				end
				`REG_PC:          pc_d = avs_writedata[20:0];
				`REG_UPPER_LATCH: begin
					counter_upper_latch_d = avs_writedata[7:0];
				end
				`REG_HIGH_LATCH: begin
					counter_high_latch_d = avs_writedata[7:0];
				end
				`REG_FILE_ADDR:   file_addr_d = avs_writedata[11:0];
				`REG_FILE_DATA: begin
					mem_we = 1'b1;
				end
				default: begin
					// Unmapped write is dropped
				end
			endcase
		end

		// Execution of the launched instruction
		// A return spends its second cycle in ST_RET_NOP, which keeps
		// the next request waiting for the full two cycles
		case (state_q)
			ST_IDLE: begin
				// Waiting for software to launch a word
			end
			ST_EXEC: begin
				if (dec.is_ret) begin
					pc_d = stack_top_entry_q;
					if (dec.shadow) begin
						acc_d             = accumulator_shadow_q;
						flags_d           = flag_shadow_q;
						bank_select_reg_d = bank_choice_shadow_q;
					end
					// Flags change here only through the shadow copy
					// latches untouched
					counter_upper_latch_d = counter_upper_latch_q;
					counter_high_latch_d  = counter_high_latch_q;
					state_d = ST_RET_NOP;
				end else if (dec.is_rot) begin
					// Source byte is read without a clock; bank register
					// and operand are both settled since the launch edge
					// one-cycle rotate
					flags_d[`FLAG_C] = rot_src[7];
					flags_d[`FLAG_N] = rot_res[7];
					flags_d[`FLAG_Z] = (rot_res == `RST_BYTE);
					if (dec.dest) begin
						mem_we    = 1'b1;
						mem_addr  = rot_addr;
						mem_wdata = rot_res;
					end else begin
						acc_d = rot_res;
					end
					state_d = ST_IDLE;
				end else begin
					// Unknown words do nothing but flag the error
					illegal_d = 1'b1;
					state_d   = ST_IDLE;
				end
			end
			ST_RET_NOP: begin
				// Second return cycle, an idle slot
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase

		// Bus answer: one wait cycle, held longer while executing
		// A request is only answered from the idle state, so the
		// slower path costs latency but never a torn register view;
		// a launch forces the wait so the next access sees the result
		waitreq_d = !((avs_read || avs_write) && waitreq_q &&
			(state_q == ST_IDLE));
		if (launch) begin
			waitreq_d = 1'b1;
		end

		// Read data is prepared during the wait cycle
		// Recomputed on every wait cycle, so a read held off by a
		// running instruction returns the values after it finished
		rdata_d = rdata_q;
		if ((avs_read || avs_write) && waitreq_q) begin
			rdata_d = 32'h0000_0000;
			case (avs_address)
				`REG_INSTR: rdata_d = {16'h0000, instr_q};
				`REG_CTRL: begin
					rdata_d[`CTRL_BUSY]    = (state_q != ST_IDLE);
					rdata_d[`CTRL_ILLEGAL] = illegal_q;
				end
				`REG_ACC:         rdata_d[7:0]  = acc_q;
				`REG_FLAGS:       rdata_d[7:0]  = flags_q;
				`REG_BANK:        rdata_d[3:0]  = bank_select_reg_q;
				`REG_ACC_SHD:     rdata_d[7:0]  = accumulator_shadow_q;
				`REG_FLAG_SHD:    rdata_d[7:0]  = flag_shadow_q;
				`REG_BANK_SHD:    rdata_d[3:0]  = bank_choice_shadow_q;
				`REG_STACK_TOP:   rdata_d[20:0] = stack_top_entry_q;
				`REG_PC:          rdata_d[20:0] = pc_q;
				`REG_UPPER_LATCH: rdata_d[7:0]  = counter_upper_latch_q;
				`REG_HIGH_LATCH:  rdata_d[7:0]  = counter_high_latch_q;
				`REG_FILE_ADDR:   rdata_d[11:0] = file_addr_q;
				`REG_FILE_DATA:   rdata_d[7:0]  = file_mem[file_addr_q];
				default: begin
					// Unmapped reads return zero
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
		if (bus_rd) begin
			// Hold the answer through the completing edge
			rdata_d = rdata_q;
		end
	end

	// State registers; reset gives constants only
	// Every register loads on every edge; holds come from the defaults
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q               <= ST_IDLE;
			instr_q               <= 16'h0000;
			illegal_q             <= 1'b0;
			acc_q                 <= `RST_BYTE;
			flags_q               <= `RST_BYTE;
			bank_select_reg_q     <= 4'h0;
			accumulator_shadow_q  <= `RST_BYTE;
			flag_shadow_q         <= `RST_BYTE;
			bank_choice_shadow_q  <= 4'h0;
			stack_top_entry_q     <= `RST_PC;
			pc_q                  <= `RST_PC;
			counter_upper_latch_q <= `RST_BYTE;
			counter_high_latch_q  <= `RST_BYTE;
			file_addr_q           <= 12'h000;
			waitreq_q             <= 1'b1;
			rdata_q               <= 32'h0000_0000;
		end else begin
			state_q               <= state_d;
			instr_q               <= instr_d;
			illegal_q             <= illegal_d;
			acc_q                 <= acc_d;
			flags_q               <= flags_d;
			bank_select_reg_q     <= bank_select_reg_d;
			accumulator_shadow_q  <= accumulator_shadow_d;
			flag_shadow_q         <= flag_shadow_d;
			bank_choice_shadow_q  <= bank_choice_shadow_d;
			stack_top_entry_q     <= stack_top_entry_d;
			pc_q                  <= pc_d;
			counter_upper_latch_q <= counter_upper_latch_d;
			counter_high_latch_q  <= counter_high_latch_d;
			file_addr_q           <= file_addr_d;
			waitreq_q             <= waitreq_d;
			rdata_q               <= rdata_d;
		end
	end

	// Data memory write port; no reset, contents start unknown
	// Leaving the array without reset keeps it a plain RAM; software
	// must write a byte before a rotate reads it
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			file_mem[mem_addr] <= mem_wdata;
		end
	end

	// Outputs come straight from flip-flops
	assign avs_waitrequest = waitreq_q;
	assign avs_readdata    = rdata_q;
endmodule : subroutine_return_and_rotate_exec

// >>> tb/exec_checker.sv
`timescale 1ns/1ns
`include "exec_defines.svh"
// Watches the register bus of the execution block
module exec_checker (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Read accepted at this edge
	logic rd_done;
	assign rd_done = avs_read && !avs_waitrequest;
	// Write accepted at this edge
	logic        wr_done;
	logic [20:0] top_seen;  // Last stack top written by software
	logic [20:0] pc_exp;    // Counter value the rules predict
	assign wr_done = avs_write && !avs_waitrequest;

	// Track the counter from bus writes alone
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			top_seen <= `RST_PC;
			pc_exp   <= `RST_PC;
		end else if (wr_done) begin
			if (avs_address == `REG_STACK_TOP) begin
				top_seen <= avs_writedata[20:0];
			end
			if (avs_address == `REG_PC) begin
				pc_exp <= avs_writedata[20:0];
			end
			// A launched return pops the stack top
			if (avs_address == `REG_INSTR &&
				avs_writedata[15:1] == `RET_PATTERN) begin
				pc_exp <= top_seen;
			end
		end
	end

	chk_ret_pc_load: assert property (
		rd_done && avs_address == `REG_PC |-> avs_readdata[20:0] == pc_exp)
		else $error("counter read differs from popped stack top");

	chk_wait_single: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_wait_cause: assert property (
		!avs_waitrequest |-> (avs_read || avs_write))
		else $error("answer without a request");
	chk_answer_bound: assert property (
		(avs_read || avs_write) && avs_waitrequest
		|-> ##[1:8] !avs_waitrequest)
		else $error("request not answered in time");
	chk_pc_width: assert property (
		rd_done && avs_address == `REG_PC |-> avs_readdata[31:21] == 11'h000)
		else $error("counter read has upper bits set");
	chk_acc_width: assert property (
		rd_done && avs_address == `REG_ACC |-> avs_readdata[31:8] == 24'h0)
		else $error("accumulator read has upper bits set");
	chk_flag_width: assert property (
		rd_done && avs_address == `REG_FLAGS |-> avs_readdata[31:8] == 24'h0)
		else $error("flag read has upper bits set");
	chk_bank_width: assert property (
		rd_done && avs_address == `REG_BANK |-> avs_readdata[31:4] == 28'h0)
		else $error("bank read has upper bits set");
	chk_file_width: assert property (
		rd_done && avs_address == `REG_FILE_DATA
		|-> avs_readdata[31:8] == 24'h0)
		else $error("file byte read has upper bits set");
endmodule : exec_checker

bind subroutine_return_and_rotate_exec exec_checker chk_u (
	.sys_clk         (sys_clk),
	.rst_n           (rst_n),
	.avs_address     (avs_address),
	.avs_read        (avs_read),
	.avs_write       (avs_write),
	.avs_writedata   (avs_writedata),
	.avs_readdata    (avs_readdata),
	.avs_waitrequest (avs_waitrequest)
);

// >>> tb/test_subroutine_return_and_rotate_exec.sv
`timescale 1ns/1ns
`include "exec_defines.svh"
module test_subroutine_return_and_rotate_exec;
	logic        sys_clk;     // 10 MHz core clock
	logic        rst_n;       // Active low reset
	logic [5:0]  avs_address; // Bus address
	logic        avs_read;    // Read strobe
	logic        avs_write;   // Write strobe
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          num_errors;  // Mismatch count
	int          compares;    // Comparison count
	logic [31:0] rv;          // Last read value
	logic [7:0]  res;         // Expected rotate result
	logic [7:0]  flg;         // Flag value before rotate

	subroutine_return_and_rotate_exec dut_u (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest)
	);

	// Clock generator, 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// One bus cycle; held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		// A stuck slave counts as a mismatch
		if (n >= 50) begin
			num_errors++;
			$display("[FAIL] %0t bus hang", $time);
		end
		rv = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// Compare one read word with the expected value
	task automatic chk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		compares++;
		if (rv !== e) begin
			num_errors++;
			$display("[FAIL] %0t addr %h got %h exp %h", $time, a, rv, e);
		end
	endtask : chk

	// Rotate case: value, carry in, dest, access, bank, file operand
	task automatic rot(input logic [7:0] v, input logic c, input logic d,
		input logic a, input logic [3:0] b, input logic [7:0] f);
		logic [3:0] eb;
		eb = a ? b : (f < 8'h60 ? 4'h0 : 4'hF);
		flg = 8'hEA | {7'h0, c};
		res = {v[6:0], c};
		bus(1'b1, `REG_BANK, {28'h0, b});
		bus(1'b1, `REG_FILE_ADDR, {20'h0, eb, f});
		bus(1'b1, `REG_FILE_DATA, {24'h0, v});
		bus(1'b1, `REG_FLAGS, {24'h0, flg});
		bus(1'b1, `REG_ACC, 32'h0000005A);
		bus(1'b1, `REG_INSTR, {16'h0, 6'h0D, d, a, f});
		chk(`REG_FILE_DATA, {24'h0, d ? res : v});
		chk(`REG_ACC, {24'h0, d ? 8'h5A : res});
		chk(`REG_FLAGS, {24'h0, (flg & 8'hEA) | {3'h0, res[7], 1'b0,
			res == 8'h00, 1'b0, v[7]}});
	endtask : rot

	// Return case with or without shadow restore
	task automatic ret(input logic s);
		bus(1'b1, `REG_ACC, 32'h00000011);
		bus(1'b1, `REG_FLAGS, 32'h00000005);
		bus(1'b1, `REG_BANK, 32'h00000002);
		bus(1'b1, `REG_ACC_SHD, 32'h000000A7);
		bus(1'b1, `REG_FLAG_SHD, 32'h00000010);
		bus(1'b1, `REG_BANK_SHD, 32'h0000000C);
		bus(1'b1, `REG_STACK_TOP, {11'h0, 20'h4D2B6, s});
		bus(1'b1, `REG_UPPER_LATCH, 32'h00000013);
		bus(1'b1, `REG_HIGH_LATCH, 32'h0000006E);
		bus(1'b1, `REG_INSTR, {16'h0, 15'h0009, s});
		chk(`REG_PC, {11'h0, 20'h4D2B6, s});
		chk(`REG_ACC, s ? 32'h000000A7 : 32'h00000011);
		chk(`REG_FLAGS, s ? 32'h00000010 : 32'h00000005);
		chk(`REG_BANK, s ? 32'h0000000C : 32'h00000002);
		chk(`REG_UPPER_LATCH, 32'h00000013);
		chk(`REG_HIGH_LATCH, 32'h0000006E);
		chk(`REG_CTRL, 32'h00000000);
	endtask : ret

	// Verdict and end of run
	task automatic end_sim;
		if (num_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// Watchdog: tests take a few hundred cycles
	initial begin
		#(100 * 20000);
		num_errors++;
		$display("[FAIL] %0t watchdog timeout", $time);
		end_sim();
	end

	// Main sequence
	initial begin
		num_errors = 0;
		compares = 0;
		rst_n = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk(`REG_PC, 32'h0);
		chk(`REG_ACC, 32'h0);
		chk(6'h3C, 32'h0);
		rot(8'hC3, 1'b1, 1'b1, 1'b1, 4'h3, 8'hFF);
		rot(8'h80, 1'b0, 1'b0, 1'b0, 4'h7, 8'h10);
		rot(8'h41, 1'b1, 1'b1, 1'b0, 4'h2, 8'h60);
		// Unknown word: only the sticky error flag may change
		bus(1'b1, `REG_INSTR, 32'h0000FFFF);
		chk(`REG_CTRL, 32'h00000002);
		bus(1'b1, `REG_CTRL, 32'h00000002);
		chk(`REG_CTRL, 32'h00000000);
		ret(1'b0);
		ret(1'b1);
		end_sim();
	end
endmodule : test_subroutine_return_and_rotate_exec
